// [common/dhp_map.vh]
`ifndef DHP_MAP_VH
`define DHP_MAP_VH
// Sync/sleep pin function select codes
`define DHP_SS_SYNC      2'h0
`define DHP_SS_TXEN      2'h1
`define DHP_SS_SLEEP     2'h2
// Serial frame geometry
`define DHP_SER_ADDR_BITS 4'h8
`define DHP_SER_DATA_BITS 4'h8
`define DHP_SER_FRAME     5'h10
// Register addresses inside the serial map
`define DHP_REG_CFG1      7'h01
`define DHP_REG_CFG3      7'h03
`define DHP_REG_ALARM     7'h07
`define DHP_REG_STATUS    7'h08
// Field positions
`define DHP_CFG1_SWAP     0
`define DHP_CFG1_PHASE8   1
`define DHP_CFG1_CLKOUT   2
`define DHP_CFG3_4WIRE    0
`define DHP_CFG3_SS_LO    1
`define DHP_ALM_FULL      0
`define DHP_ALM_EMPTY     1
// Reset values
`define DHP_CFG1_RST      8'h00
`define DHP_CFG3_RST      8'h00
`define DHP_ALM_RST       8'h00
// Data clock divider when driven out (half period in clk cycles)
`define DHP_CLKDIV_HALF   4'h4
`endif

// [verilog/dhp_host_port.v]
// What this block does
// - Alarm pin driven low on enabled alarms
// - Four-wire mode turns alarm pin into read-out
// - Reset pin low resets all logic except the pin synchronisers and the data clock output level
// - Three-wire mode turns data pin around
// - Four-wire mode never drives data pin
// - Data clock pin is input or output
// - Sample bus fourteen bits, bit 13 MSB
// - Interleaved I and Q split to two channels
// - Full phase word every sample clock
// - Phase halves alternate: top eight bits, then top six bits
// - Marker high with swap zero means first
// - Sync/sleep pin function chosen by setting
// - Input FIFO decouples data and converter clocks
`include "dhp_map.vh"
`timescale 1ns/1ps
`default_nettype none
module dhp_host_port (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        reset_n_pin_i,
  input  wire        sclk_i,
  input  wire        serial_enable_n_i,
  input  wire        sdio_i,
  output reg         sdio_o,
  output reg         sdio_oe_o,
  output reg         alarm_or_serial_out_o,
  input  wire        data_clk_i,
  output reg         data_clk_o,
  output reg         data_clk_oe_o,
  input  wire [13:0] data_i,
  input  wire        channel_marker_i,
  input  wire        sync_sleep_i,
  input  wire        conv_take_i,
  output reg  [13:0] conv_first_o,
  output reg  [13:0] conv_second_o,
  output reg  [13:0] phase_word_o,
  output reg         conv_valid_o,
  output reg         sync_o,
  output reg         tx_enable_o,
  output reg         sleep_o
);
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg  [1:0]  rstn_s_q;
  reg  [1:0]  sclk_s_q;
  reg  [1:0]  sen_s_q;
  reg  [1:0]  sdi_s_q;
  reg  [1:0]  dclk_s_q;
  reg  [1:0]  mark_s_q;
  reg  [1:0]  ss_s_q;
  reg  [13:0] data_s1_q;
  reg  [13:0] data_s2_q;
  reg         sclk_d1_q;
  reg         dclk_d1_q;
  wire        soft_rst;
  assign soft_rst = ~rstn_s_q[1];

  // Two flops on every outside input except conv_take_i
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rstn_s_q  <= 2'h0;
      sclk_s_q  <= 2'h0;
      sen_s_q   <= 2'h3;
      sdi_s_q   <= 2'h0;
      dclk_s_q  <= 2'h0;
      mark_s_q  <= 2'h0;
      ss_s_q    <= 2'h0;
      data_s1_q <= 14'h0000;
      data_s2_q <= 14'h0000;
      sclk_d1_q <= 1'b0;
      dclk_d1_q <= 1'b0;
    end else begin
      rstn_s_q  <= {rstn_s_q[0], reset_n_pin_i};
      sclk_s_q  <= {sclk_s_q[0], sclk_i};
      sen_s_q   <= {sen_s_q[0], serial_enable_n_i};
      sdi_s_q   <= {sdi_s_q[0], sdio_i};
      dclk_s_q  <= {dclk_s_q[0], data_clk_i};
      mark_s_q  <= {mark_s_q[0], channel_marker_i};
      ss_s_q    <= {ss_s_q[0], sync_sleep_i};
      data_s1_q <= data_i;
      data_s2_q <= data_s1_q;
      sclk_d1_q <= sclk_s_q[1];
      dclk_d1_q <= dclk_s_q[1];
    end
  end

  wire sclk_rise = sclk_s_q[1] & ~sclk_d1_q;
  wire sclk_fall = ~sclk_s_q[1] & sclk_d1_q;
  wire sen_act   = ~sen_s_q[1];

  ////////////////////////////////////////////////////////////////////////
  // Serial port: 1 r/w bit, 7 address bits, 8 data bits
  reg  [7:0] cfg1_q;
  reg  [7:0] cfg3_q;
  reg  [7:0] alm_en_q;
  reg  [4:0] bit_cnt_q;
  reg  [7:0] shift_q;
  reg  [7:0] rd_q;
  reg        rd_mode_q;
  wire       four_wire_serial_mode = cfg3_q[`DHP_CFG3_4WIRE];
  wire [1:0] ss_sel = cfg3_q[`DHP_CFG3_SS_LO+1:`DHP_CFG3_SS_LO];
  reg  [7:0] status_q;

  // Read mux for the serial map
  function [7:0] reg_read;
    input [6:0] addr;
    begin
      case (addr)
        `DHP_REG_CFG1:  reg_read = cfg1_q;
        `DHP_REG_CFG3:  reg_read = cfg3_q;
        `DHP_REG_ALARM: reg_read = alm_en_q;
        `DHP_REG_STATUS: reg_read = status_q;
        default:        reg_read = 8'h00;
      endcase
    end
  endfunction

  reg  [6:0] addr_q;
  reg  [7:0] st_clr_q;
  wire [7:0] wr_byte = {shift_q[6:0], sdi_s_q[1]};

  // Frame shifter and register writes
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg1_q    <= `DHP_CFG1_RST;
      cfg3_q    <= `DHP_CFG3_RST;
      alm_en_q  <= `DHP_ALM_RST;
      bit_cnt_q <= 5'h00;
      shift_q   <= 8'h00;
      rd_q      <= 8'h00;
      rd_mode_q <= 1'b0;
      addr_q    <= 7'h00;
      st_clr_q  <= 8'h00;
    end else if (soft_rst) begin
      cfg1_q    <= `DHP_CFG1_RST;
      cfg3_q    <= `DHP_CFG3_RST;
      alm_en_q  <= `DHP_ALM_RST;
      bit_cnt_q <= 5'h00;
      shift_q   <= 8'h00;
      rd_q      <= 8'h00;
      rd_mode_q <= 1'b0;
      addr_q    <= 7'h00;
      st_clr_q  <= 8'h00;
    end else if (!sen_act) begin
      bit_cnt_q <= 5'h00;
      rd_mode_q <= 1'b0;
      st_clr_q  <= 8'h00;
    end else if (sclk_rise && bit_cnt_q < `DHP_SER_FRAME) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
      shift_q   <= wr_byte;
      st_clr_q  <= 8'h00;
      if (bit_cnt_q == 5'h00) begin
        rd_mode_q <= sdi_s_q[1];
      end
      if (bit_cnt_q == 5'h07) begin
        addr_q <= wr_byte[6:0];
        rd_q   <= reg_read(wr_byte[6:0]);
      end
      if (bit_cnt_q == 5'h0f && !rd_mode_q) begin
        case (addr_q)
          `DHP_REG_CFG1:   cfg1_q   <= wr_byte;
          `DHP_REG_CFG3:   cfg3_q   <= wr_byte;
          `DHP_REG_ALARM:  alm_en_q <= wr_byte;
          `DHP_REG_STATUS: st_clr_q <= wr_byte;
          default: ;
        endcase
      end
    end else begin
      st_clr_q <= 8'h00;
      // First read bit stands until the host has sampled it
      if (sclk_fall && rd_mode_q && bit_cnt_q > 5'h08) begin
        rd_q <= {rd_q[6:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data clock, sample pairing and input FIFO
  reg  [3:0]  div_q;
  reg  [13:0] hold_q;
  reg  [27:0] fifo_q [0:3];
  reg  [2:0]  wr_ptr_q;
  reg  [2:0]  rd_ptr_q;
  integer     i;
  wire        clk_out_en = cfg1_q[`DHP_CFG1_CLKOUT];
  wire        swap       = cfg1_q[`DHP_CFG1_SWAP];
  wire        phase8     = cfg1_q[`DHP_CFG1_PHASE8];
  wire        div_wrap   = (div_q == `DHP_CLKDIV_HALF - 4'h1);
  wire        out_rise   = clk_out_en & div_wrap & ~data_clk_o;
  wire        in_rise    = dclk_s_q[1] & ~dclk_d1_q;
  wire        strobe     = clk_out_en ? out_rise : in_rise;
  wire        mark       = mark_s_q[1];
  wire        fifo_empty = (wr_ptr_q == rd_ptr_q);
  wire        fifo_full  = (wr_ptr_q[1:0] == rd_ptr_q[1:0]) &&
                           (wr_ptr_q[2] != rd_ptr_q[2]);
  wire        push       = strobe & ~mark;
  wire        pop        = conv_take_i & ~fifo_empty;
  wire        over_ev    = push & fifo_full;
  wire        under_ev   = conv_take_i & fifo_empty;
  // Marker-high word is first unless swapped
  wire [27:0] pair = swap ? {data_s2_q, hold_q}
                          : {hold_q, data_s2_q};

  // Data clock driven out; it holds its level when turned off
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q         <= 4'h0;
      data_clk_o    <= 1'b0;
      data_clk_oe_o <= 1'b0;
    end else if (soft_rst) begin
      div_q         <= 4'h0;
      data_clk_oe_o <= 1'b0;
    end else begin
      data_clk_oe_o <= clk_out_en;
      if (clk_out_en) begin
        div_q <= div_wrap ? 4'h0 : div_q + 4'h1;
        if (div_wrap) begin
          data_clk_o <= ~data_clk_o;
        end
      end else begin
        div_q <= 4'h0;
      end
    end
  end

  // Pair capture, FIFO between data and converter sides
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i || soft_rst) begin
      hold_q        <= 14'h0000;
      wr_ptr_q      <= 3'h0;
      rd_ptr_q      <= 3'h0;
      conv_first_o  <= 14'h0000;
      conv_second_o <= 14'h0000;
      conv_valid_o  <= 1'b0;
      phase_word_o  <= 14'h0000;
      for (i = 0; i < 4; i = i + 1) begin
        fifo_q[i] <= 28'h0000000;
      end
    end else begin
      conv_valid_o <= pop;
      if (pop) begin
        conv_first_o  <= fifo_q[rd_ptr_q[1:0]][27:14];
        conv_second_o <= fifo_q[rd_ptr_q[1:0]][13:0];
        rd_ptr_q      <= rd_ptr_q + 3'h1;
      end
      if (strobe && mark) begin
        hold_q <= data_s2_q;
      end
      if (push && !fifo_full) begin
        fifo_q[wr_ptr_q[1:0]] <= pair;
        wr_ptr_q              <= wr_ptr_q + 3'h1;
      end
      if (strobe && !phase8) begin
        phase_word_o <= data_s2_q;
      end else if (strobe && !mark) begin
        phase_word_o <= {hold_q[13:6], data_s2_q[13:8]};
      end
    end
  end

  // Sticky FIFO error flags; a new event beats a clear
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_q <= 8'h00;
    end else if (soft_rst) begin
      status_q <= 8'h00;
    end else begin
      status_q[`DHP_ALM_FULL]  <= over_ev |
        (status_q[`DHP_ALM_FULL] & ~st_clr_q[`DHP_ALM_FULL]);
      status_q[`DHP_ALM_EMPTY] <= under_ev |
        (status_q[`DHP_ALM_EMPTY] & ~st_clr_q[`DHP_ALM_EMPTY]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial data pin and alarm pin drivers
  wire rd_drive = rd_mode_q & sen_act & (bit_cnt_q > 5'h07);

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sdio_o                <= 1'b0;
      sdio_oe_o             <= 1'b0;
      alarm_or_serial_out_o <= 1'b1;
    end else if (soft_rst) begin
      sdio_o                <= 1'b0;
      sdio_oe_o             <= 1'b0;
      alarm_or_serial_out_o <= 1'b1;
    end else begin
      sdio_o <= rd_q[7];
      if (four_wire_serial_mode) begin
        sdio_oe_o             <= 1'b0;
        alarm_or_serial_out_o <= rd_drive ? rd_q[7] : 1'b1;
      end else begin
        sdio_oe_o             <= rd_drive;
        alarm_or_serial_out_o <= ~(|(alm_en_q & status_q));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sync/sleep pin function decode
  reg ss_d1_q;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ss_d1_q     <= 1'b0;
      sync_o      <= 1'b0;
      tx_enable_o <= 1'b0;
      sleep_o     <= 1'b0;
    end else if (soft_rst) begin
      ss_d1_q     <= 1'b0;
      sync_o      <= 1'b0;
      tx_enable_o <= 1'b0;
      sleep_o     <= 1'b0;
    end else begin
      ss_d1_q     <= ss_s_q[1];
      sync_o      <= (ss_sel == `DHP_SS_SYNC) & ss_s_q[1] & ~ss_d1_q;
      tx_enable_o <= (ss_sel == `DHP_SS_TXEN) & ss_s_q[1];
      sleep_o     <= (ss_sel == `DHP_SS_SLEEP) & ss_s_q[1];
    end
  end
endmodule
`default_nettype wire

// [testbench/dhp_host_port_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module dhp_host_port_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reset_n_pin_i,
  input wire logic serial_enable_n_i,
  input wire logic sdio_oe_o,
  input wire logic alarm_or_serial_out_o,
  input wire logic data_clk_o,
  input wire logic data_clk_oe_o,
  input wire logic conv_valid_o,
  input wire logic sync_o,
  input wire logic tx_enable_o,
  input wire logic sleep_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Pin and mode checks
  alm_idle_a: assert property ($fell(rst_i) |-> alarm_or_serial_out_o[*4])
    else $error("alarm low after reset");
  pin_reset_a: assert property (!reset_n_pin_i[*4] |->
    alarm_or_serial_out_o && !conv_valid_o && !sdio_oe_o)
    else $error("pin reset ignored");
  sdio_idle_a: assert property (serial_enable_n_i[*4] |-> !sdio_oe_o)
    else $error("data pin driven outside frame");
  clk_half_a: assert property (data_clk_oe_o && $changed(data_clk_o)
    |=> $stable(data_clk_o)[*3]) else $error("data clock half period");
  ss_one_a: assert property ($onehot0({sync_o, tx_enable_o, sleep_o}))
    else $error("sync sleep functions overlap");
  ss_rst_a: assert property ($fell(rst_i) |-> !sleep_o && !tx_enable_o)
    else $error("sync sleep default wrong");
  clk_in_a: assert property ($fell(rst_i) |-> !data_clk_oe_o)
    else $error("data clock driven after reset");
  alm_pin_a: assert property ($rose(reset_n_pin_i) |-> alarm_or_serial_out_o[*2])
    else $error("alarm low after pin reset");
endmodule
bind dhp_host_port dhp_host_port_sva i_sva (.clk_i, .rst_i, .reset_n_pin_i,
  .serial_enable_n_i, .sdio_oe_o, .alarm_or_serial_out_o, .data_clk_o,
  .data_clk_oe_o, .conv_valid_o, .sync_o, .tx_enable_o, .sleep_o);
`default_nettype wire

// [testbench/dhp_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dhp_host_model (
  input  wire logic clk_i,
  input  wire logic sd_i,
  input  wire logic sdo_i,
  output var logic  sclk_o,
  output var logic  sen_n_o,
  output var logic  sd_o,
  output var logic  sd_oe_o
);
  initial {sclk_o, sen_n_o, sd_o, sd_oe_o} = 4'h4;
  // One bit: data set, clock rises (sample taken), clock falls
  task bit_cyc(input logic b, output logic s, input logic w);
    sd_o = b;
    repeat (8) @(negedge clk_i);
    sclk_o = 1;
    s = w ? sdo_i : sd_i;
    repeat (8) @(negedge clk_i);
    sclk_o = 0;
  endtask
  // Framed transfer, clock still between frames; rd reads back
  task xfer(input logic rd, input logic [6:0] ad, input logic [7:0] dt,
            input logic w, output logic [7:0] q);
    logic s;
    sen_n_o = 0;
    sd_oe_o = 1;
    bit_cyc(rd, s, w);
    for (int k = 6; k >= 0; k--) bit_cyc(ad[k], s, w);
    sd_oe_o = !rd;
    for (int k = 7; k >= 0; k--) begin
      bit_cyc(dt[k], s, w);
      q[k] = s;
    end
    sd_oe_o = 0;
    repeat (8) @(negedge clk_i);
    sen_n_o = 1;
    repeat (8) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// [testbench/dhp_host_port_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module dhp_host_port_tb;
  logic        clk_i = 0, rst_i = 1, reset_n_pin_i = 1, data_clk_i = 0;
  logic        channel_marker_i = 0, conv_take_i = 0, sync_sleep_i = 0;
  logic        oe_seen = 0;
  logic [2:0]  seen = 0;
  logic [7:0]  q;
  logic [13:0] data_i = 0, a, b;
  logic [15:0] lf = 16'he689, r = 16'he689;
  wire         sclk_i, serial_enable_n_i, h_d, h_oe, sdio_o, sdio_oe_o;
  wire         alarm_or_serial_out_o, data_clk_o, data_clk_oe_o;
  wire         conv_valid_o, sync_o, tx_enable_o, sleep_o;
  wire [13:0]  conv_first_o, conv_second_o, phase_word_o;
  wire sdio_i = sdio_oe_o ? sdio_o : h_oe & h_d; // Pull-down when released
  integer bad_count = 0, checks_done = 0, cyc = 0;
  initial forever #4 clk_i = ~clk_i;
  initial forever #62.5 data_clk_i = ~data_clk_i;
  function [15:0] nx(input [15:0] v);
    nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  dhp_host_model p (.clk_i, .sd_i(sdio_i), .sdo_i(alarm_or_serial_out_o),
    .sclk_o(sclk_i), .sen_n_o(serial_enable_n_i), .sd_o(h_d), .sd_oe_o(h_oe));
  dhp_host_port i_dut (.clk_i, .rst_i, .reset_n_pin_i, .sclk_i,
    .serial_enable_n_i, .sdio_i, .sdio_o, .sdio_oe_o, .alarm_or_serial_out_o,
    .data_clk_i, .data_clk_o, .data_clk_oe_o, .data_i, .channel_marker_i,
    .sync_sleep_i, .conv_take_i, .conv_first_o, .conv_second_o,
    .phase_word_o, .conv_valid_o, .sync_o, .tx_enable_o, .sleep_o);
  // Sticky records of pulses and of the data pin being driven
  always @(posedge clk_i) begin
    if (!rst_i) begin
      if (sdio_oe_o) oe_seen <= 1;
      seen <= seen | {sync_o, conv_valid_o, data_clk_o};
    end
  end
  task chk(input [13:0] s, e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %0t seen %h want %h", $time, s, e);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Interleaved pair, marker high with first word
  task send(input [13:0] x, y);
    repeat (16) begin
      @(negedge data_clk_i) @(negedge clk_i);
      channel_marker_i = ~channel_marker_i;
      data_i = channel_marker_i ? x : y;
    end
  endtask
  // Random take strobe and hang limit
  always @(negedge clk_i) begin
    r = nx(r);
    conv_take_i = r[0];
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop;
    end
  end
  initial begin
    repeat (16) @(negedge clk_i);
    rst_i = 0;
    repeat (2) @(negedge clk_i);
    chk(alarm_or_serial_out_o, 1'h1);
    chk(data_clk_oe_o, 1'h0);
    // Plain pairs, swapped pairs, split phase words
    for (int i = 0; i < 3; i++) begin
      lf = nx(lf);
      a = lf[13:0];
      lf = nx(lf);
      b = lf[13:0];
      p.xfer(0, 7'h01, i[7:0], 0, q);
      chk(sdio_oe_o, 1'h0);
      send(a, b);
      repeat (40) @(negedge clk_i);
      chk(conv_first_o, i == 1 ? b : a);
      chk(conv_second_o, i == 1 ? a : b);
      if (i == 2) chk(phase_word_o, {a[13:6], b[13:8]});
      else chk(phase_word_o, b);
    end
    // Three-wire read back, then four-wire read on the alarm pin
    p.xfer(1, 7'h01, 8'h00, 0, q);
    chk(q, 8'h02);
    chk(oe_seen, 1'h1);
    p.xfer(0, 7'h03, 8'h01, 0, q);
    oe_seen = 0;
    p.xfer(1, 7'h03, 8'h00, 1, q);
    chk(q, 8'h01);
    chk(oe_seen, 1'h0);
    p.xfer(0, 7'h03, 8'h00, 0, q);
    // Each sync/sleep function in turn
    for (int m = 0; m < 3; m++) begin
      p.xfer(0, 7'h03, {5'h00, m[1:0], 1'b0}, 0, q);
      sync_sleep_i = 1;
      repeat (6) @(negedge clk_i);
      chk(tx_enable_o, m == 1);
      chk(sleep_o, m == 2);
      sync_sleep_i = 0;
      repeat (4) @(negedge clk_i);
    end
    chk(seen[2], 1'h1);
    // Data clock driven out
    p.xfer(0, 7'h01, 8'h04, 0, q);
    repeat (20) @(negedge clk_i);
    chk(data_clk_oe_o, 1'h1);
    chk(seen[0], 1'h1);
    p.xfer(0, 7'h01, 8'h00, 0, q);
    // Takes on an empty FIFO flag underflow and raise the alarm
    p.xfer(1, 7'h08, 8'h00, 0, q);
    chk(q[1], 1'h1);
    chk(seen[1], 1'h1);
    p.xfer(0, 7'h07, 8'h02, 0, q);
    repeat (4) @(negedge clk_i);
    chk(alarm_or_serial_out_o, 1'h0);
    // Pin reset in mid-run clears the alarm and the settings
    reset_n_pin_i = 0;
    repeat (4) @(negedge clk_i);
    reset_n_pin_i = 1;
    chk(alarm_or_serial_out_o, 1'h1);
    repeat (4) @(negedge clk_i);
    chk(alarm_or_serial_out_o, 1'h1);
    p.xfer(1, 7'h07, 8'h00, 0, q);
    chk(q, 8'h00);
    report_and_stop;
  end
endmodule
`default_nettype wire
